// [src/gpio_ports_regs.vh]
// Register offsets, reset values and field positions of the three-port GPIO block
`ifndef GPIO_PORTS_REGS_VH
`define GPIO_PORTS_REGS_VH

// ****************************************************************
// Register offsets (byte addresses on the plain register port)
// ****************************************************************
`define ADDR_W 5
`define DATA_W 8
`define OFS_FIRST_LATCH 5'h00
`define OFS_FIRST_DIR 5'h01
`define OFS_FIRST_PULLUP 5'h02
`define OFS_SECOND_LATCH 5'h04
`define OFS_SECOND_DIR 5'h05
`define OFS_SECOND_PULLUP 5'h06
`define OFS_IN_BUF_TYPE 5'h07
`define OFS_OUT_DRIVE_TYPE 5'h08
`define OFS_THIRD_LATCH 5'h0C
`define OFS_THIRD_DIR 5'h0D
`define OFS_THIRD_PULLUP 5'h0E
`define OFS_ANALOG_DIGITAL 5'h10
`define OFS_ADC_CHANNEL 5'h11
`define OFS_PIN_SWAP 5'h12

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_LATCH 8'h00
`define RST_DIR 8'hFF
`define RST_PULLUP 8'h00
`define RST_BUF_TYPE 8'h00
`define RST_ANALOG_DIGITAL 8'h00
`define RST_ADC_CHANNEL 8'h00
`define RST_PIN_SWAP 8'h00
`define RD_UNMAPPED 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define SWAP_SERIAL_BIT 0
`define ADC_CH_W 5
`define ADC_FIRST_CH 5'h08
`define SMB_PINS 2

`endif

// [src/gpio_pin_cell.v]
// One general-purpose I/O pin cell: drive, pull-up and read-back path
`timescale 1ns/1ps

module gpio_pin_cell #(
   parameter HAS_PU = 1,
   parameter HAS_OD = 0
) (
   input wire sys_clk_i,   // System clock
   input wire arst_n_i,    // Async reset, active low
   input wire latch_i,     // Output latch bit
   input wire dir_in_i,    // 1 = input mode
   input wire pu_sel_i,    // Pull-up select bit
   input wire od_sel_i,    // 1 = open-drain drive
   input wire alt_out_i,   // Alternate function output
   input wire dig_en_i,    // Digital function enabled
   input wire pin_i,       // Pin level seen by input buffer
   output reg pin_o,       // Pin output value
   output reg pin_oe_o,    // Pin output enable
   output reg pu_en_o,     // Pull-up enable
   output wire rd_o        // Read-back value
);

   reg next_val;
   reg next_oe;
   reg next_out;

   // ****************************************************************
   // Drive path
   // ****************************************************************
   always @* begin
      next_val = latch_i | alt_out_i;
      next_out = next_val;
      next_oe = dig_en_i & ~dir_in_i;
      if ((HAS_OD != 0) && od_sel_i) begin
         // Open drain only pulls low, a one releases the pin
         next_out = 1'b0;
         next_oe = dig_en_i & ~dir_in_i & ~next_val;
      end
   end

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_o <= 1'b0;
         pin_oe_o <= 1'b0;
         pu_en_o <= 1'b0;
      end else begin
         pin_o <= next_out;
         pin_oe_o <= next_oe;
         pu_en_o <= (HAS_PU != 0) & dir_in_i & pu_sel_i;
      end
   end

   // Input bits return the pin, output bits the latch
   assign rd_o = dir_in_i ? (pin_i & dig_en_i) : latch_i;

endmodule // gpio_pin_cell

// [src/gpio_ports.v]
// Three-port general-purpose I/O block with alternate functions
//
// Behaviour
// - Per-pin output latch and direction bit.
// - First port input pull-up per select bit.
// - Second port input pull-up per select bit.
// - Third port pull-up only on largest package.
// - Reset sets all directions to input.
// - Two low second-port pins pick SMBus buffer.
// - Second port pins pick CMOS or open drain.
// - First port carries interrupt, counter clocks, select.
// - Swap moves serial clock and data input onto first port, largest package only.
// - Second port carries serial data, clock, clock.
// - Third port: analog inputs or key interrupts.
// - Digital mode, unselected channel: normal digital pin.
// - Analog input converted only when channel picks.
`timescale 1ns/1ps
`include "gpio_ports_regs.vh"

module gpio_ports #(
   parameter FIRST_W = 3,
   parameter SECOND_W = 4,
   parameter THIRD_W = 6,
   parameter ANALOG_W = 3,
   parameter LARGE_PKG = 1,
   parameter HAS_ADC = 1
) (
   input wire sys_clk_i,                   // System clock, 125 MHz
   input wire arst_n_i,                    // Async reset, active low
   input wire [`ADDR_W-1:0] addr_i,        // Register address
   input wire [`DATA_W-1:0] wdata_i,       // Register write data
   input wire wr_i,                        // Write strobe
   input wire rd_i,                        // Read strobe
   output reg [`DATA_W-1:0] rdata_o,       // Read data, cycle after strobe
   input wire [FIRST_W-1:0] first_pin_i,   // First port pin levels
   output wire [FIRST_W-1:0] first_pin_o,  // First port pin drive values
   output wire [FIRST_W-1:0] first_pin_oe_o, // First port output enables
   output wire [FIRST_W-1:0] first_pu_en_o, // First port pull-up enables
   input wire [SECOND_W-1:0] second_pin_i, // Second port normal buffer levels
   input wire [`SMB_PINS-1:0] second_smb_i, // SMBus buffer levels, two low pins
   output wire [SECOND_W-1:0] second_pin_o, // Second port pin drive values
   output wire [SECOND_W-1:0] second_pin_oe_o, // Second port output enables
   output wire [SECOND_W-1:0] second_pu_en_o, // Second port pull-up enables
   input wire [THIRD_W-1:0] third_pin_i,   // Third port pin levels
   output wire [THIRD_W-1:0] third_pin_o,  // Third port pin drive values
   output wire [THIRD_W-1:0] third_pin_oe_o, // Third port output enables
   output wire [THIRD_W-1:0] third_pu_en_o, // Third port pull-up enables
   output reg [ANALOG_W-1:0] analog_en_o,  // Pin handed to analog input
   output reg [ANALOG_W-1:0] adc_convert_o, // Pin is the converted channel
   input wire rtc_clk_i,                   // Real-time counter clock out
   input wire rtc_corr_clk_i,              // Real-time counter correction clock
   input wire sck_out_i,                   // Serial clock from serial unit
   input wire sdo_i,                       // Serial data from serial unit
   output reg sck_in_o,                    // Serial clock / external clock in
   output reg sdi_o,                       // Serial data into serial unit
   output reg ssel_n_o,                    // Serial chip select, active low
   output reg ext_int_o,                   // External interrupt from first port
   output reg [SECOND_W-1:0] second_int_o, // Interrupt inputs on second port
   output reg [THIRD_W-1:0] key_int_o      // Key interrupt inputs
);

   // ****************************************************************
   // Register file
   // ****************************************************************
   reg [FIRST_W-1:0] first_port_latch;
   reg [FIRST_W-1:0] first_port_direction;
   reg [FIRST_W-1:0] first_port_pullup_select;
   reg [SECOND_W-1:0] second_port_latch;
   reg [SECOND_W-1:0] second_port_direction;
   reg [SECOND_W-1:0] second_port_pullup_select;
   reg [`SMB_PINS-1:0] input_buffer_type_select;
   reg [SECOND_W-1:0] output_drive_type_select;
   reg [THIRD_W-1:0] third_port_latch;
   reg [THIRD_W-1:0] third_port_direction;
   reg [THIRD_W-1:0] third_port_pullup_select;
   reg [ANALOG_W-1:0] analog_digital_pin_select;
   reg [`ADC_CH_W-1:0] adc_channel_select;
   reg alternate_pin_swap;

   wire swap_on;
   wire [FIRST_W-1:0] first_rd;
   wire [SECOND_W-1:0] second_rd;
   wire [THIRD_W-1:0] third_rd;
   wire [SECOND_W-1:0] second_in;
   wire [THIRD_W-1:0] third_dig_en;
   reg [FIRST_W-1:0] first_alt;
   reg [SECOND_W-1:0] second_alt;
   reg [`DATA_W-1:0] next_rdata;

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         first_port_latch <= {FIRST_W{1'b0}};
         first_port_direction <= {FIRST_W{1'b1}};
         first_port_pullup_select <= {FIRST_W{1'b0}};
         second_port_latch <= {SECOND_W{1'b0}};
         second_port_direction <= {SECOND_W{1'b1}};
         second_port_pullup_select <= {SECOND_W{1'b0}};
         input_buffer_type_select <= {`SMB_PINS{1'b0}};
         output_drive_type_select <= {SECOND_W{1'b0}};
         third_port_latch <= {THIRD_W{1'b0}};
         third_port_direction <= {THIRD_W{1'b1}};
         third_port_pullup_select <= {THIRD_W{1'b0}};
         analog_digital_pin_select <= {ANALOG_W{1'b0}};
         adc_channel_select <= {`ADC_CH_W{1'b0}};
         alternate_pin_swap <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            `OFS_FIRST_LATCH: begin
               first_port_latch <= wdata_i[FIRST_W-1:0];
            end
            `OFS_FIRST_DIR: begin
               first_port_direction <= wdata_i[FIRST_W-1:0];
            end
            `OFS_FIRST_PULLUP: begin
               first_port_pullup_select <= wdata_i[FIRST_W-1:0];
            end
            `OFS_SECOND_LATCH: begin
               second_port_latch <= wdata_i[SECOND_W-1:0];
            end
            `OFS_SECOND_DIR: begin
               second_port_direction <= wdata_i[SECOND_W-1:0];
            end
            `OFS_SECOND_PULLUP: begin
               second_port_pullup_select <= wdata_i[SECOND_W-1:0];
            end
            `OFS_IN_BUF_TYPE: begin
               input_buffer_type_select <= wdata_i[`SMB_PINS-1:0];
            end
            `OFS_OUT_DRIVE_TYPE: begin
               output_drive_type_select <= wdata_i[SECOND_W-1:0];
            end
            `OFS_THIRD_LATCH: begin
               third_port_latch <= wdata_i[THIRD_W-1:0];
            end
            `OFS_THIRD_DIR: begin
               third_port_direction <= wdata_i[THIRD_W-1:0];
            end
            `OFS_THIRD_PULLUP: begin
               // Smaller packages have no pull-up control here
               if (LARGE_PKG != 0) begin
                  third_port_pullup_select <= wdata_i[THIRD_W-1:0];
               end
            end
            `OFS_ANALOG_DIGITAL: begin
               if (HAS_ADC != 0) begin
                  analog_digital_pin_select <= wdata_i[ANALOG_W-1:0];
               end
            end
            `OFS_ADC_CHANNEL: begin
               adc_channel_select <= wdata_i[`ADC_CH_W-1:0];
            end
            `OFS_PIN_SWAP: begin
               if (LARGE_PKG != 0) begin
                  alternate_pin_swap <= wdata_i[`SWAP_SERIAL_BIT];
               end
            end
            default: begin
               first_port_latch <= first_port_latch;
            end
         endcase
      end
   end

   // ****************************************************************
   // Read-back
   // ****************************************************************
   always @* begin
      next_rdata = `RD_UNMAPPED;
      case (addr_i)
         `OFS_FIRST_LATCH: begin
            next_rdata[FIRST_W-1:0] = first_rd;
         end
         `OFS_FIRST_DIR: begin
            next_rdata[FIRST_W-1:0] = first_port_direction;
         end
         `OFS_FIRST_PULLUP: begin
            next_rdata[FIRST_W-1:0] = first_port_pullup_select;
         end
         `OFS_SECOND_LATCH: begin
            next_rdata[SECOND_W-1:0] = second_rd;
         end
         `OFS_SECOND_DIR: begin
            next_rdata[SECOND_W-1:0] = second_port_direction;
         end
         `OFS_SECOND_PULLUP: begin
            next_rdata[SECOND_W-1:0] = second_port_pullup_select;
         end
         `OFS_IN_BUF_TYPE: begin
            next_rdata[`SMB_PINS-1:0] = input_buffer_type_select;
         end
         `OFS_OUT_DRIVE_TYPE: begin
            next_rdata[SECOND_W-1:0] = output_drive_type_select;
         end
         `OFS_THIRD_LATCH: begin
            next_rdata[THIRD_W-1:0] = third_rd;
         end
         `OFS_THIRD_DIR: begin
            next_rdata[THIRD_W-1:0] = third_port_direction;
         end
         `OFS_THIRD_PULLUP: begin
            next_rdata[THIRD_W-1:0] = third_port_pullup_select;
         end
         `OFS_ANALOG_DIGITAL: begin
            next_rdata[ANALOG_W-1:0] = analog_digital_pin_select;
         end
         `OFS_ADC_CHANNEL: begin
            next_rdata[`ADC_CH_W-1:0] = adc_channel_select;
         end
         `OFS_PIN_SWAP: begin
            next_rdata[`SWAP_SERIAL_BIT] = alternate_pin_swap;
         end
         default: begin
            next_rdata = `RD_UNMAPPED;
         end
      endcase
   end

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= `RD_UNMAPPED;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= `RD_UNMAPPED;
      end
   end

   // ****************************************************************
   // Alternate output routing
   // ****************************************************************
   assign swap_on = (LARGE_PKG != 0) & alternate_pin_swap;

   // Peripheral outputs are ORed with the latch; software keeps the latch low
   always @* begin
      first_alt = {FIRST_W{1'b0}};
      first_alt[0] = rtc_clk_i | (swap_on & sck_out_i);
      first_alt[1] = rtc_corr_clk_i;
      second_alt = {SECOND_W{1'b0}};
      second_alt[0] = ~swap_on & sck_out_i;
      second_alt[2] = sdo_i;
   end

   // ****************************************************************
   // Second port input buffer choice
   // ****************************************************************
   genvar k;
   generate
      for (k = 0; k < SECOND_W; k = k + 1) begin : g_in_buf
         if (k < `SMB_PINS) begin : g_smb
            assign second_in[k] = input_buffer_type_select[k] ?
                                  second_smb_i[k] : second_pin_i[k];
         end else begin : g_norm
            assign second_in[k] = second_pin_i[k];
         end
      end
   endgenerate

   // ****************************************************************
   // Third port analog/digital steering
   // ****************************************************************
   generate
      for (k = 0; k < THIRD_W; k = k + 1) begin : g_dig_en
         if ((k < ANALOG_W) && (HAS_ADC != 0)) begin : g_ana
            assign third_dig_en[k] = ~analog_digital_pin_select[k];
         end else begin : g_dig
            assign third_dig_en[k] = 1'b1;
         end
      end
   endgenerate

   integer j;
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         analog_en_o <= {ANALOG_W{1'b0}};
         adc_convert_o <= {ANALOG_W{1'b0}};
      end else begin
         for (j = 0; j < ANALOG_W; j = j + 1) begin
            // Analog needs input mode; analog with output mode gives neither
            analog_en_o[j] <= analog_digital_pin_select[j] &
                              third_port_direction[j];
            adc_convert_o[j] <= analog_digital_pin_select[j] &
                                third_port_direction[j] &
                                (adc_channel_select ==
                                 (`ADC_FIRST_CH + j[`ADC_CH_W-1:0]));
         end
      end
   end

   // ****************************************************************
   // Pin cells
   // ****************************************************************
   generate
      for (k = 0; k < FIRST_W; k = k + 1) begin : g_first
         gpio_pin_cell #(.HAS_PU(1), .HAS_OD(0)) u_cell (
            .sys_clk_i(sys_clk_i),
            .arst_n_i(arst_n_i),
            .latch_i(first_port_latch[k]),
            .dir_in_i(first_port_direction[k]),
            .pu_sel_i(first_port_pullup_select[k]),
            .od_sel_i(1'b0),
            .alt_out_i(first_alt[k]),
            .dig_en_i(1'b1),
            .pin_i(first_pin_i[k]),
            .pin_o(first_pin_o[k]),
            .pin_oe_o(first_pin_oe_o[k]),
            .pu_en_o(first_pu_en_o[k]),
            .rd_o(first_rd[k])
         );
      end
      for (k = 0; k < SECOND_W; k = k + 1) begin : g_second
         gpio_pin_cell #(.HAS_PU(1), .HAS_OD(1)) u_cell (
            .sys_clk_i(sys_clk_i),
            .arst_n_i(arst_n_i),
            .latch_i(second_port_latch[k]),
            .dir_in_i(second_port_direction[k]),
            .pu_sel_i(second_port_pullup_select[k]),
            .od_sel_i(output_drive_type_select[k]),
            .alt_out_i(second_alt[k]),
            .dig_en_i(1'b1),
            .pin_i(second_in[k]),
            .pin_o(second_pin_o[k]),
            .pin_oe_o(second_pin_oe_o[k]),
            .pu_en_o(second_pu_en_o[k]),
            .rd_o(second_rd[k])
         );
      end
      for (k = 0; k < THIRD_W; k = k + 1) begin : g_third
         gpio_pin_cell #(.HAS_PU(LARGE_PKG), .HAS_OD(0)) u_cell (
            .sys_clk_i(sys_clk_i),
            .arst_n_i(arst_n_i),
            .latch_i(third_port_latch[k]),
            .dir_in_i(third_port_direction[k]),
            .pu_sel_i(third_port_pullup_select[k]),
            .od_sel_i(1'b0),
            .alt_out_i(1'b0),
            .dig_en_i(third_dig_en[k]),
            .pin_i(third_pin_i[k]),
            .pin_o(third_pin_o[k]),
            .pin_oe_o(third_pin_oe_o[k]),
            .pu_en_o(third_pu_en_o[k]),
            .rd_o(third_rd[k])
         );
      end
   endgenerate

   // ****************************************************************
   // Alternate inputs toward peripherals
   // ****************************************************************
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_in_o <= 1'b0;
         sdi_o <= 1'b0;
         ssel_n_o <= 1'b1;
         ext_int_o <= 1'b0;
         second_int_o <= {SECOND_W{1'b0}};
         key_int_o <= {THIRD_W{1'b0}};
      end else begin
         sck_in_o <= swap_on ? first_pin_i[0] : second_in[0];
         sdi_o <= swap_on ? first_pin_i[1] : second_in[1];
         ssel_n_o <= first_pin_i[FIRST_W-1];
         ext_int_o <= first_pin_i[FIRST_W-1];
         second_int_o <= second_in;
         // Key inputs are silent while a pin is given to the analog side
         key_int_o <= third_pin_i & third_dig_en;
      end
   end

endmodule // gpio_ports

// [testbench/gpio_board.sv]
// Board-side model of the nets attached to one port
`timescale 1ns/1ps

module gpio_board #(
   parameter W = 8
) (
   input wire [W-1:0] pin_o_i, // Block drive value
   input wire [W-1:0] oe_i,    // Block output enable
   input wire [W-1:0] pu_i,    // On-chip pull-up enable
   input wire [W-1:0] ext_i,   // Level of the board net when released
   output wire [W-1:0] lvl_o   // Pin level
);
   // Released pins float to the pull-up or the board's own level
   assign lvl_o = (oe_i & pin_o_i) | (~oe_i & (pu_i | ext_i));
endmodule // gpio_board

// [testbench/gpio_ports_chk.sv]
// Port-level assertions for the three-port GPIO block
`timescale 1ns/1ps
`include "gpio_ports_regs.vh"

module gpio_ports_chk #(
   parameter FIRST_W = 3,
   parameter SECOND_W = 4,
   parameter THIRD_W = 6,
   parameter ANALOG_W = 3
) (
   input wire sys_clk_i, // Clock
   input wire arst_n_i, // Reset
   input wire [`ADDR_W-1:0] addr_i, // Address
   input wire [`DATA_W-1:0] wdata_i, // Write data
   input wire wr_i, // Write strobe
   input wire rd_i, // Read strobe
   input wire [`DATA_W-1:0] rdata_o, // Read data
   input wire [FIRST_W-1:0] first_pin_i, // Pin levels
   input wire [FIRST_W-1:0] first_pin_oe_o, // Enables
   input wire [FIRST_W-1:0] first_pu_en_o, // Pull-ups
   input wire [SECOND_W-1:0] second_pin_oe_o, // Enables
   input wire [SECOND_W-1:0] second_pu_en_o, // Pull-ups
   input wire [THIRD_W-1:0] third_pin_oe_o, // Enables
   input wire [ANALOG_W-1:0] analog_en_o, // Analog pins
   input wire [ANALOG_W-1:0] adc_convert_o, // Converted pin
   input wire ssel_n_o, // Chip select
   input wire ext_int_o // Interrupt
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_rst_all_input: assert property ($rose(arst_n_i) |-> first_pin_oe_o == 0 &&
      second_pin_oe_o == 0 && third_pin_oe_o == 0) else $error("pin driven after reset");
   a_dir_to_enable: assert property ($past(wr_i, 2) && $past(addr_i, 2) == `OFS_FIRST_DIR
      && !($past(wr_i) && $past(addr_i) == `OFS_FIRST_DIR)
      |-> first_pin_oe_o == ~$past(wdata_i[FIRST_W-1:0], 2)) else $error("enable not ~dir");
   a_first_pu_input: assert property ((first_pu_en_o & first_pin_oe_o) == 0)
      else $error("first pull-up on output");
   a_second_pu_input: assert property ((second_pu_en_o & second_pin_oe_o) == 0)
      else $error("second pull-up on output");
   a_read_pin_level: assert property (rd_i && addr_i == `OFS_FIRST_LATCH && !$past(wr_i)
      && first_pin_oe_o == 0 |=> rdata_o[FIRST_W-1:0] == $past(first_pin_i))
      else $error("read not pin level");
   a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data without read");
   a_select_follows_pin: assert property ($past(arst_n_i) |->
      ext_int_o == $past(first_pin_i[2]) && ssel_n_o == ext_int_o) else $error("select path");
   a_analog_no_drive: assert property ((analog_en_o & third_pin_oe_o[ANALOG_W-1:0]) == 0
      && (adc_convert_o & ~analog_en_o) == 0) else $error("analog pin misuse");
endmodule // gpio_ports_chk

bind gpio_ports gpio_ports_chk #(.FIRST_W(FIRST_W), .SECOND_W(SECOND_W), .THIRD_W(THIRD_W),
   .ANALOG_W(ANALOG_W)) u_gpio_ports_chk (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .first_pin_i, .first_pin_oe_o, .first_pu_en_o, .second_pin_oe_o,
   .second_pu_en_o, .third_pin_oe_o, .analog_en_o, .adc_convert_o, .ssel_n_o, .ext_int_o);

// [testbench/gpio_ports_tb_top.sv]
// Self-checking testbench for the three-port GPIO block
`timescale 1ns/1ps
`include "gpio_ports_regs.vh"

module gpio_ports_tb_top;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rtc = 1'b0;
   logic sck_out = 1'b0; // Serial unit idle outside its scenario
   logic [1:0] flip = 2'h0;
   logic [7:0] ext [3] = '{8'h05, 8'h0A, 8'h2C};
   logic [7:0] msk [3] = '{8'h07, 8'h0F, 8'h3F};
   logic [4:0] bas [3] = '{`OFS_FIRST_LATCH, `OFS_SECOND_LATCH, `OFS_THIRD_LATCH};
   logic [15:0] seed = 16'h0037;
   int bad_count = 0;
   int num_checks = 0;
   wire [7:0] rdata;
   wire [7:0] po [3];
   wire [7:0] oe [3];
   wire [7:0] pu [3];
   wire [7:0] lv [3];
   wire [2:0] an;
   wire [2:0] cv;
   wire sck_in;
   wire sdi;
   wire [3:0] si;
   wire [5:0] ki;

   always #4 sys_clk_i = ~sys_clk_i;

   gpio_ports u_gpio_ports (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .first_pin_i(lv[0][2:0]),
      .first_pin_o(po[0][2:0]), .first_pin_oe_o(oe[0][2:0]), .first_pu_en_o(pu[0][2:0]),
      .second_pin_i(lv[1][3:0]), .second_smb_i(lv[1][1:0] ^ flip), .second_pin_o(po[1][3:0]),
      .second_pin_oe_o(oe[1][3:0]), .second_pu_en_o(pu[1][3:0]), .third_pin_i(lv[2][5:0]),
      .third_pin_o(po[2][5:0]), .third_pin_oe_o(oe[2][5:0]), .third_pu_en_o(pu[2][5:0]),
      .analog_en_o(an), .adc_convert_o(cv), .rtc_clk_i(rtc), .rtc_corr_clk_i(rtc),
      .sck_out_i(sck_out), .sdo_i(rtc), .sck_in_o(sck_in), .sdi_o(sdi),
      .ssel_n_o(), .ext_int_o(), .second_int_o(si), .key_int_o(ki));

   // Bits above each port's width carry no pin
   assign {po[0][7:3], oe[0][7:3], pu[0][7:3]} = 15'h0000;
   assign {po[1][7:4], oe[1][7:4], pu[1][7:4]} = 12'h000;
   assign {po[2][7:6], oe[2][7:6], pu[2][7:6]} = 6'h00;

   for (genvar k = 0; k < 3; k++) begin : g_brd
      gpio_board u_gpio_board (.pin_o_i(po[k]), .oe_i(oe[k]), .pu_i(pu[k]), .ext_i(ext[k]),
         .lvl_o(lv[k]));
   end

   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask

   task automatic settle();
      repeat (3) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      $display("Error watchdog expected done seen hang");
      results();
   end

   initial begin
      logic [7:0] l, d, u, x;
      repeat (3) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         rd_chk(bas[p] + 5'h01, msk[p]);
         rd_chk(bas[p], ext[p] & msk[p]);
         repeat (6) begin
            l = rnd();
            d = rnd();
            u = rnd();
            x = rnd();
            ext[p] <= x;
            wr_reg(bas[p], l);
            wr_reg(bas[p] + 5'h01, d);
            wr_reg(bas[p] + 5'h02, u);
            settle();
            chk("oe", ~d & msk[p], oe[p] & msk[p]);
            chk("po", l & ~d & msk[p], po[p] & ~d & msk[p]);
            chk("pu", u & d & msk[p], pu[p] & msk[p]);
            rd_chk(bas[p], ((l & ~d) | ((u | x) & d)) & msk[p]);
            rd_chk(bas[p] + 5'h01, d & msk[p]);
         end
         $display("port %0d done", p);
      end
      wr_reg(`OFS_SECOND_DIR, 8'h00);
      wr_reg(`OFS_SECOND_LATCH, 8'h05);
      wr_reg(`OFS_OUT_DRIVE_TYPE, 8'h0F);
      settle();
      chk("od_oe", 8'h0A, oe[1] & 8'h0F);
      chk("od_po", 8'h00, po[1] & 8'h0F);
      rd_chk(`OFS_SECOND_LATCH, 8'h05);
      wr_reg(`OFS_OUT_DRIVE_TYPE, 8'h00);
      settle();
      chk("cmos", 8'h05, po[1] & oe[1] & 8'h0F);
      wr_reg(`OFS_SECOND_DIR, 8'hFF);
      wr_reg(`OFS_SECOND_PULLUP, 8'h00);
      x = rnd() & 8'h0F;
      ext[1] <= x;
      flip <= 2'h3;
      wr_reg(`OFS_IN_BUF_TYPE, 8'h03);
      settle();
      rd_chk(`OFS_SECOND_LATCH, x ^ 8'h03);
      chk("sec_int", x ^ 8'h03, {4'h0, si});
      wr_reg(`OFS_IN_BUF_TYPE, 8'h00);
      settle();
      rd_chk(`OFS_SECOND_LATCH, x);
      $display("drive and buffer done");
      wr_reg(`OFS_FIRST_DIR, 8'hFF);
      wr_reg(`OFS_FIRST_PULLUP, 8'h00);
      for (int s = 0; s < 2; s++) begin
         wr_reg(`OFS_PIN_SWAP, s[7:0]);
         ext[0] <= rnd();
         ext[1] <= rnd();
         settle();
         chk("sck_in", s ? ext[0][0] : ext[1][0], sck_in);
         chk("sdi", s ? ext[0][1] : ext[1][1], sdi);
      end
      wr_reg(`OFS_FIRST_DIR, 8'h00);
      wr_reg(`OFS_FIRST_LATCH, 8'h00);
      wr_reg(`OFS_SECOND_LATCH, 8'h00);
      sck_out <= 1'b1;
      settle();
      chk("sck_out", 8'h01, po[0] & 8'h07);
      chk("sck_swap", 8'h00, po[1] & 8'h0F);
      rtc <= 1'b1;
      wr_reg(`OFS_PIN_SWAP, 8'h00);
      settle();
      chk("rtc", 8'h03, po[0] & 8'h07);
      chk("sec_alt", 8'h05, po[1] & 8'h0F);
      sck_out <= 1'b0;
      rtc <= 1'b0;
      $display("alternate routing done");
      wr_reg(`OFS_THIRD_DIR, 8'hFF);
      wr_reg(`OFS_THIRD_PULLUP, 8'h00);
      wr_reg(`OFS_ANALOG_DIGITAL, 8'h07);
      for (int c = 8; c < 11; c++) begin
         wr_reg(`OFS_ADC_CHANNEL, c[7:0]);
         settle();
         chk("analog", 8'h07, {5'h00, an});
         chk("convert", 8'h01 << (c - 8), {5'h00, cv});
      end
      chk("key", ext[2] & 8'h38, {2'h0, ki});
      rd_chk(`OFS_THIRD_LATCH, ext[2] & 8'h38);
      wr_reg(`OFS_ANALOG_DIGITAL, 8'h00);
      wr_reg(`OFS_THIRD_DIR, 8'h00);
      settle();
      chk("digital", 8'h00, {5'h00, an | cv});
      chk("dig_oe", 8'h3F, oe[2] & 8'h3F);
      wr_reg(5'h1F, 8'hFF);
      rd_chk(5'h1F, 8'h00);
      $display("analog and unmapped done");
      results();
   end
endmodule // gpio_ports_tb_top
